// File: bench/ssr_far_model.sv
// Purpose: far-side serial device in either clock role
// Assumes: clock wire idles low
// Notes:   after the hold time the data line shows the inverse
`timescale 1ns/1ns
module ssr_far_model
(
  // shared clock wire level
  input  wire logic ck_wire,
  // lines this side drives
  output logic      ck_out,
  output logic      dt_out
);
  logic [31:0] stream;
  int          hold;

  initial
  begin
    ck_out = 1'b0;
    dt_out = 1'b0;
    stream = 32'h0;
    hold   = 5;
  end

  // next bit on the leading edge, lsb first
  always @(posedge ck_wire)
  begin
    dt_out = stream[0];
    stream = stream >> 1;
  end

  // hold time over, line no longer valid
  always @(negedge ck_wire)
  begin
    #(hold) dt_out = ~dt_out;
  end

  // clock master: one cycle per data bit only
  task automatic drive_char(input logic [8:0] val, input int nb);
    stream = 32'(val);
    hold   = 40;
    // step off the core clock edge
    #3;
    repeat (nb)
    begin
      #80 ck_out = 1'b1;
      #80 ck_out = 1'b0;
    end
    #80 hold = 5;
  endtask
endmodule

// File: bench/ssr_rx_monitor.sv
// Purpose: port-level checks of the receive port
// Assumes: control registers mirrored from bus writes
// Notes:   mirror ignores hardware clearing of single
`timescale 1ns/1ns
`include "ssr_defines.svh"
module ssr_rx_monitor
  import ssr_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              reset,
  // register bus
  input wire ssr_bus_req_type   bus_req,
  input wire logic [7:0]        rd_data,
  // pins and status
  input wire logic              clock_pin_in,
  input wire ssr_pin_drive_type clock_pin_drv,
  input wire logic              data_pin_in,
  input wire ssr_pin_drive_type data_pin_drv,
  input wire logic              rx_pending_flag
);
  logic [7:0]  rs_r, ts_r, dv_r;
  logic [10:0] hi_r, half_w;
  logic        en_w, rsw_w, hrd_w;

  // decoded bus events and expected half period
  assign en_w   = rs_r[`SSR_RS_SINGLE_RX] | rs_r[`SSR_RS_CONT_RX];
  assign rsw_w  = bus_req.wr && bus_req.addr == `SSR_OFS_RX_STATUS_CONTROL;
  assign hrd_w  = bus_req.rd && bus_req.addr == `SSR_OFS_RX_HOLDING;
  assign half_w = (11'(dv_r) + 11'h001) * (ts_r[`SSR_TS_HIGH_SPEED] ? `SSR_SCALE_HIGH_SPEED : `SSR_SCALE_LOW_SPEED);

  // mirror of control writes
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rs_r <= `SSR_RST_RX_STATUS_CONTROL;
      ts_r <= `SSR_RST_TX_STATUS_CONTROL;
      dv_r <= `SSR_RST_BAUD_DIVISOR;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == `SSR_OFS_RX_STATUS_CONTROL) rs_r <= bus_req.wdata;
      if (bus_req.addr == `SSR_OFS_TX_STATUS_CONTROL) ts_r <= bus_req.wdata;
      if (bus_req.addr == `SSR_OFS_BAUD_DIVISOR) dv_r <= bus_req.wdata;
    end
  end

  // cycles the bit clock has stood high
  always_ff @(posedge core_clk)
  begin
    if (reset || !clock_pin_drv.out)
      hi_r <= 11'h000;
    else
      hi_r <= hi_r + 11'h001;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence abort_wr_s;
    rsw_w && !bus_req.wdata[`SSR_RS_SINGLE_RX] && !bus_req.wdata[`SSR_RS_CONT_RX];
  endsequence
  sequence clk_quiet_s;
    (!clock_pin_drv.out) [*3];
  endsequence

  data_drv_off_a:
    assert property (data_pin_drv.oe == 1'b0) else $error("data pin driven");
  clk_drv_mode_a:
    assert property (clock_pin_drv.oe == (rs_r[`SSR_RS_PORT_ENABLE] & ts_r[`SSR_TS_SYNC_MODE]
                                          & ts_r[`SSR_TS_CLOCK_SOURCE]))
      else $error("clock drive mode wrong");
  rd_idle_zero_a:
    assert property (!$past(bus_req.rd) |-> rd_data == 8'h00) else $error("read data outside slot");
  empty_read_a:
    assert property (!rx_pending_flag && hrd_w |=> rd_data == 8'h00) else $error("empty read not zero");
  pend_hold_a:
    assert property (rx_pending_flag && rs_r[`SSR_RS_PORT_ENABLE] && !hrd_w
                     && !(rsw_w && !bus_req.wdata[`SSR_RS_PORT_ENABLE]) |=> rx_pending_flag)
      else $error("pending dropped early");
  high_time_a:
    assert property ($fell(clock_pin_drv.out) && en_w |-> hi_r == half_w) else $error("bit clock high time");
  gate_clock_a:
    assert property (!en_w && !$past(en_w) && !$past(en_w, 2) |-> !$rose(clock_pin_drv.out))
      else $error("clock without enable");
  abort_stop_a:
    assert property (abort_wr_s |-> ##2 clk_quiet_s) else $error("clock kept running");
  port_off_a:
    assert property (rsw_w && !bus_req.wdata[`SSR_RS_PORT_ENABLE] |=> ##1 !rx_pending_flag)
      else $error("disable kept data");
endmodule

bind ssr_rx_port ssr_rx_monitor mon (.core_clk(core_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
  .clock_pin_in(clock_pin_in), .clock_pin_drv(clock_pin_drv), .data_pin_in(data_pin_in),
  .data_pin_drv(data_pin_drv), .rx_pending_flag(rx_pending_flag));

// File: bench/tb_sync_serial_receive_port.sv
// Purpose: self-checking bench for the receive port
// Assumes: offsets 0 rx ctl, 1 tx ctl, 2 divisor, 3 rx data
// Notes:   address detect always kept clear
`timescale 1ns/1ns
module tb_sync_serial_receive_port;
  import ssr_pkg::*;
  logic              core_clk, reset, ck_wire, far_ck, far_dt;
  ssr_bus_req_type   bus_req;
  logic [7:0]        rd_data, v;
  ssr_pin_drive_type ck_drv, dt_drv;
  logic              rx_pending_flag;
  logic [8:0]        c [3];
  int                error_cnt, samples_checked, rises, n, r;

  // clock wire idles low when nobody drives
  assign ck_wire = ck_drv.oe ? ck_drv.out : far_ck;

  ssr_rx_port DUT (.core_clk(core_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
    .clock_pin_in(ck_wire), .clock_pin_drv(ck_drv), .data_pin_in(dt_drv.oe ? dt_drv.out : far_dt),
    .data_pin_drv(dt_drv), .rx_pending_flag(rx_pending_flag));
  ssr_far_model far (.ck_wire(ck_wire), .ck_out(far_ck), .dt_out(far_dt));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // count master bit clocks
  always @(posedge ck_drv.out) rises++;

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tmo();
    if (n >= 3000)
    begin
      error_cnt++;
      $display("unexpected at %0t: wait ran out", $time);
      summarize();
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic wait_pend();
    for (n = 0; n < 3000 && rx_pending_flag !== 1'b1; n++)
      @(posedge core_clk);
    tmo();
  endtask

  initial
  begin
    reset = 1'b1;
    bus_req = '0;
    error_cnt = 0;
    samples_checked = 0;
    rises = 0;
    v = 8'h00;
    void'($urandom(98));
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    // reset values, write-only and unmapped places
    wr(3'h4, 8'($urandom));
    wr(3'h7, 8'hff);
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), v);
      chk(v, (a == 1) ? 9'h002 : 9'h000);
    end
    $display("done: reset values");
    // master single receive at random rates
    for (int i = 0; i < 4; i++)
    begin
      c[0] = 9'($urandom);
      far.stream = 32'(c[0]);
      wr(3'h2, 8'($urandom_range(4, 2)));
      wr(3'h1, {5'b10010, 1'($urandom), 2'b00});
      rises = 0;
      wr(3'h0, 8'ha0);
      wait_pend();
      rd(3'h5, v);
      chk(v[5], 1'b1);
      chk(dt_drv, 9'h000);
      rd(3'h0, v);
      chk(v[5], 1'b0);
      rd(3'h3, v);
      chk(v, c[0][7:0]);
      chk(rx_pending_flag, 1'b0);
      chk(rises, 8);
    end
    $display("done: single receive");
    // nine bits, both enables, three characters for two slots
    for (int i = 0; i < 3; i++)
      c[i] = 9'($urandom);
    far.stream = {5'h00, c[2], c[1], c[0]};
    wr(3'h1, 8'h94);
    wr(3'h2, 8'h02);
    rises = 0;
    wr(3'h0, 8'hf0);
    v = 8'h00;
    for (n = 0; n < 3000 && v[1] !== 1'b1; n++)
      rd(3'h0, v);
    tmo();
    chk(v[5], 1'b0);
    chk(rises, 27);
    for (int i = 0; i < 2; i++)
    begin
      rd(3'h0, v);
      chk(v[0], c[i][8]);
      rd(3'h3, v);
      chk(v, c[i][7:0]);
    end
    rd(3'h0, v);
    chk(v[1], 1'b1);
    wr(3'h0, 8'hc0);
    rd(3'h0, v);
    chk(v[1], 1'b0);
    $display("done: overrun");
    // continuous stopped in mid-character
    far.stream = 32'($urandom);
    rises = 0;
    wr(3'h0, 8'h90);
    for (n = 0; n < 3000 && rises < 3; n++)
      @(posedge core_clk);
    tmo();
    wr(3'h0, 8'h80);
    rd(3'h0, v);
    r = rises;
    repeat (3) rd(3'h0, v);
    chk(rises, r);
    chk(rx_pending_flag, 1'b0);
    c[0] = 9'($urandom);
    far.stream = 32'(c[0]);
    wr(3'h0, 8'ha0);
    wait_pend();
    rd(3'h3, v);
    chk(v, c[0][7:0]);
    // port disable drops a stored character
    wr(3'h0, 8'ha0);
    wait_pend();
    wr(3'h0, 8'h00);
    rd(3'h3, v);
    chk(v, 8'h00);
    chk(rx_pending_flag, 1'b0);
    // single-receive overrun, cleared by a holding read
    for (int i = 0; i < 3; i++)
      c[i] = 9'($urandom);
    far.stream = {8'h00, c[2][7:0], c[1][7:0], c[0][7:0]};
    for (int i = 0; i < 3; i++)
    begin
      wr(3'h0, 8'ha0);
      repeat (60) @(posedge core_clk);
    end
    rd(3'h0, v);
    chk(v[1], 1'b1);
    rd(3'h3, v);
    chk(v, c[0][7:0]);
    rd(3'h0, v);
    chk(v[1], 1'b0);
    rd(3'h3, v);
    chk(v, c[1][7:0]);
    chk(rx_pending_flag, 1'b0);
    $display("done: abort and disable");
    // slave role, partner clocks at 160 ns
    wr(3'h1, 8'h10);
    for (int nb = 8; nb < 10; nb++)
    begin
      c[0] = 9'($urandom);
      wr(3'h0, (nb == 9) ? 8'hd0 : 8'h90);
      far.drive_char(c[0], nb);
      wait_pend();
      chk(ck_drv.oe, 1'b0);
      rd(3'h0, v);
      if (nb == 9) chk(v[0], c[0][8]);
      rd(3'h3, v);
      chk(v, c[0][7:0]);
    end
    $display("done: slave receive");
    summarize();
  end
endmodule

// File: rtl/ssr_rx_port.sv
// Purpose: synchronous serial receive port, master and slave clocking
// Assumes: core_clk 100 MHz; pins sampled through ssr_sync2
// Notes:   transmit shifter not present; data pin is never driven
`timescale 1ns/1ns
`include "ssr_defines.svh"
module ssr_rx_port
  import ssr_pkg::*;
#(
  parameter int FIFO_DEPTH = 2,
  parameter int CHAR_WIDTH = 9
)
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // register bus
  input  wire ssr_bus_req_type   bus_req,
  output logic      [7:0]        rd_data,
  // clock pin
  input  wire logic              clock_pin_in,
  output ssr_pin_drive_type      clock_pin_drv,
  // data pin
  input  wire logic              data_pin_in,
  output ssr_pin_drive_type      data_pin_drv,
  // status
  output logic                   rx_pending_flag
);

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // control registers
  logic [7:0]            rx_ctl_r;
  logic [7:0]            tx_ctl_r;
  logic [7:0]            baud_divisor_r;
  logic [7:0]            tx_holding_r;
  logic                  overrun_r;
  logic                  ovr_single_r;
  // receive datapath
  logic [CHAR_WIDTH-1:0] shift_r;
  logic [3:0]            bit_cnt_r;
  logic [CHAR_WIDTH-1:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0]         wr_ptr_r;
  logic [PW-1:0]         rd_ptr_r;
  logic [CW-1:0]         count_r;
  // master clock
  ssr_ck_state_type      ck_state_r;
  logic [10:0]           div_cnt_r;
  logic                  clk_high_r;
  // slave edge detect
  logic                  s_clk;
  logic                  s_data;
  logic                  s_clk_d_r;

  // field views
  logic port_en;
  logic nine_bit;
  logic single_rx;
  logic cont_rx;
  logic sync_mode;
  logic master;
  logic high_speed;
  assign port_en    = rx_ctl_r[`SSR_RS_PORT_ENABLE];
  assign nine_bit   = rx_ctl_r[`SSR_RS_NINE_BIT];
  assign single_rx  = rx_ctl_r[`SSR_RS_SINGLE_RX];
  assign cont_rx    = rx_ctl_r[`SSR_RS_CONT_RX];
  assign sync_mode  = tx_ctl_r[`SSR_TS_SYNC_MODE];
  assign master     = tx_ctl_r[`SSR_TS_CLOCK_SOURCE];
  assign high_speed = tx_ctl_r[`SSR_TS_HIGH_SPEED];

  // bus decode
  logic wr_rxc;
  logic wr_txc;
  logic wr_baud;
  logic wr_txh;
  logic rd_rxh;
  assign wr_rxc  = bus_req.wr && (bus_req.addr == `SSR_OFS_RX_STATUS_CONTROL);
  assign wr_txc  = bus_req.wr && (bus_req.addr == `SSR_OFS_TX_STATUS_CONTROL);
  assign wr_baud = bus_req.wr && (bus_req.addr == `SSR_OFS_BAUD_DIVISOR);
  assign wr_txh  = bus_req.wr && (bus_req.addr == `SSR_OFS_TX_HOLDING);
  assign rd_rxh  = bus_req.rd && (bus_req.addr == `SSR_OFS_RX_HOLDING);

  // mode selection
  logic port_on;
  logic rx_mode;
  logic rx_active;
  logic master_rx;
  logic slave_rx;
  assign port_on   = port_en && sync_mode;
  assign rx_mode   = single_rx || cont_rx;
  assign rx_active = port_on && rx_mode && !overrun_r;
  assign master_rx = rx_active && master;
  assign slave_rx  = rx_active && !master;

  // continuous enable being cleared by software this cycle
  logic cont_clear;
  assign cont_clear = wr_rxc && cont_rx && !bus_req.wdata[`SSR_RS_CONT_RX];

  // pin synchronisers
  ssr_sync2
  #(
    .WIDTH (2)
  )
  u_pin_sync
  (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({clock_pin_in, data_pin_in}),
    .sync_out ({s_clk, s_data})
  );

  // slave clock history, fed from the second stage only
  always_ff @(posedge core_clk)
  begin
    if (reset)
      s_clk_d_r <= 1'b0;
    else
      s_clk_d_r <= s_clk;
  end

  // divider limit: half bit-clock length in core clocks minus one
  logic [10:0] half_lim;
  logic        half_tick;
  assign half_lim  = ({3'h0, baud_divisor_r} + 11'h001)
                     * (high_speed ? `SSR_SCALE_HIGH_SPEED : `SSR_SCALE_LOW_SPEED)
                     - 11'h001;
  assign half_tick = master_rx && (div_cnt_r >= half_lim);

  // divider, free while master receive runs
  always_ff @(posedge core_clk)
  begin
    if (reset || !master_rx || half_tick)
      div_cnt_r <= 11'h000;
    else
      div_cnt_r <= div_cnt_r + 11'h001;
  end

  // master clock phases
  always_ff @(posedge core_clk)
  begin
    if (reset || !port_en)
    begin
      ck_state_r <= CK_IDLE;
      clk_high_r <= 1'b0;
    end
    else if (!master_rx || (cont_clear && !single_rx))
    begin
      ck_state_r <= CK_IDLE;
      clk_high_r <= 1'b0;
    end
    else if (half_tick)
    begin
      unique case (ck_state_r)
        CK_IDLE, CK_LOW:
        begin
          ck_state_r <= CK_HIGH;
          clk_high_r <= 1'b1;
        end
        CK_HIGH:
        begin
          ck_state_r <= CK_LOW;
          clk_high_r <= 1'b0;
        end
      endcase
    end
  end

  // trailing-edge sample event from either clock source
  logic sample_evt;
  logic last_bit;
  logic char_done;
  assign sample_evt = (master_rx && half_tick && (ck_state_r == CK_HIGH))
                      || (slave_rx && s_clk_d_r && !s_clk);
  assign last_bit   = bit_cnt_r == (nine_bit ? `SSR_LAST_BIT_9 : `SSR_LAST_BIT_8);
  assign char_done  = sample_evt && last_bit;

  // completed character with the final bit merged in
  logic [CHAR_WIDTH-1:0] done_char;
  always_comb
  begin
    done_char = shift_r;
    done_char[bit_cnt_r] = s_data;
    if (!nine_bit)
      done_char[CHAR_WIDTH-1] = 1'b0;
  end

  // receive shift register and bit counter
  always_ff @(posedge core_clk)
  begin
    if (reset || !port_en)
    begin
      shift_r   <= '0;
      bit_cnt_r <= 4'h0;
    end
    else if (!rx_active || (cont_clear && !single_rx))
      bit_cnt_r <= 4'h0;
    else if (sample_evt)
    begin
      shift_r[bit_cnt_r] <= s_data;
      bit_cnt_r          <= last_bit ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  // fifo handshakes
  logic pop;
  logic full_eff;
  logic push;
  assign pop      = rd_rxh && (count_r != '0);
  assign full_eff = (count_r == CW'(FIFO_DEPTH)) && !pop;
  assign push     = char_done && !full_eff;

  // fifo storage, two entries by default
  always_ff @(posedge core_clk)
  begin
    if (push)
      fifo_mem[wr_ptr_r] <= done_char;
  end

  // fifo pointers and fill count
  always_ff @(posedge core_clk)
  begin
    if (reset || !port_en)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
      if (pop)
        rd_ptr_r <= (rd_ptr_r == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
      if (push && !pop)
        count_r <= count_r + CW'(1);
      else if (pop && !push)
        count_r <= count_r - CW'(1);
    end
  end

  assign rx_pending_flag = count_r != '0;

  // overrun flag, set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (reset || !port_en)
    begin
      overrun_r    <= 1'b0;
      ovr_single_r <= 1'b0;
    end
    else if (char_done && full_eff)
    begin
      overrun_r    <= 1'b1;
      ovr_single_r <= single_rx && !cont_rx;
    end
    else if (overrun_r && ((ovr_single_r && rd_rxh) || (!ovr_single_r && cont_clear)))
      overrun_r <= 1'b0;
  end

  // rx_status_control, hardware clears single receive after a master-mode character
  always_ff @(posedge core_clk)
  begin
    if (reset)
      rx_ctl_r <= `SSR_RST_RX_STATUS_CONTROL;
    else if (wr_rxc)
      rx_ctl_r <= bus_req.wdata;
    else if (char_done && master_rx)
      rx_ctl_r[`SSR_RS_SINGLE_RX] <= 1'b0;
  end

  // other software registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tx_ctl_r       <= `SSR_RST_TX_STATUS_CONTROL;
      baud_divisor_r <= `SSR_RST_BAUD_DIVISOR;
      tx_holding_r   <= `SSR_RST_TX_HOLDING;
    end
    else
    begin
      if (wr_txc)
        tx_ctl_r <= bus_req.wdata;
      if (wr_baud)
        baud_divisor_r <= bus_req.wdata;
      if (wr_txh)
        tx_holding_r <= bus_req.wdata;
    end
  end

  // oldest entry, zero when empty
  logic [CHAR_WIDTH-1:0] head;
  assign head = rx_pending_flag ? fifo_mem[rd_ptr_r] : '0;

  // status views assembled for reads
  logic [7:0] rx_status_view;
  logic [7:0] tx_status_view;
  logic [7:0] periph_view;
  always_comb
  begin
    rx_status_view = rx_ctl_r;
    rx_status_view[`SSR_RS_FRAMING_ERROR] = 1'b0;
    rx_status_view[`SSR_RS_OVERRUN]       = overrun_r;
    rx_status_view[`SSR_RS_NINTH_BIT]     = head[CHAR_WIDTH-1];
    tx_status_view = tx_ctl_r;
    tx_status_view[`SSR_TS_SHIFT_EMPTY]   = 1'b1;
    tx_status_view[`SSR_TS_RESERVED]      = 1'b0;
    periph_view = 8'h00;
    periph_view[`SSR_PF_RX_PENDING]       = rx_pending_flag;
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge core_clk)
  begin
    if (reset)
      rd_data <= 8'h00;
    else if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        `SSR_OFS_RX_STATUS_CONTROL: rd_data <= rx_status_view;
        `SSR_OFS_TX_STATUS_CONTROL: rd_data <= tx_status_view;
        `SSR_OFS_BAUD_DIVISOR:      rd_data <= baud_divisor_r;
        `SSR_OFS_RX_HOLDING:        rd_data <= head[7:0];
        `SSR_OFS_PERIPH_FLAG:       rd_data <= periph_view;
        default:                    rd_data <= 8'h00;
      endcase
    end
    else
      rd_data <= 8'h00;
  end

  // pin drivers
  always_comb
  begin
    clock_pin_drv.out = clk_high_r;
    clock_pin_drv.oe  = port_on && master;
    data_pin_drv.out  = 1'b0;
    data_pin_drv.oe   = 1'b0;
  end

endmodule

// File: rtl/ssr_sync2.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to core_clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module ssr_sync2
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // two stages, reset to zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// File: shared/ssr_defines.svh
// Purpose: constants for the synchronous serial receive port
// Assumes: 8-bit register data, 3-bit register address
// Notes:   offsets, field positions, reset values and clock scaling
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// register offsets
`define SSR_OFS_RX_STATUS_CONTROL 3'h0
`define SSR_OFS_TX_STATUS_CONTROL 3'h1
`define SSR_OFS_BAUD_DIVISOR      3'h2
`define SSR_OFS_RX_HOLDING        3'h3
`define SSR_OFS_TX_HOLDING        3'h4
`define SSR_OFS_PERIPH_FLAG       3'h5

// rx_status_control fields
`define SSR_RS_PORT_ENABLE    7
`define SSR_RS_NINE_BIT       6
`define SSR_RS_SINGLE_RX      5
`define SSR_RS_CONT_RX        4
`define SSR_RS_ADDR_DETECT    3
`define SSR_RS_FRAMING_ERROR  2
`define SSR_RS_OVERRUN        1
`define SSR_RS_NINTH_BIT      0

// tx_status_control fields
`define SSR_TS_CLOCK_SOURCE   7
`define SSR_TS_NINE_BIT_TX    6
`define SSR_TS_TRANSMIT_EN    5
`define SSR_TS_SYNC_MODE      4
`define SSR_TS_RESERVED       3
`define SSR_TS_HIGH_SPEED     2
`define SSR_TS_SHIFT_EMPTY    1
`define SSR_TS_TX_NINTH       0

// peripheral flag register field
`define SSR_PF_RX_PENDING     5

// reset values
`define SSR_RST_RX_STATUS_CONTROL 8'h00
`define SSR_RST_TX_STATUS_CONTROL 8'h02
`define SSR_RST_BAUD_DIVISOR      8'h00
`define SSR_RST_TX_HOLDING        8'h00

// half bit-clock period = (divisor + 1) * scale core clocks
`define SSR_SCALE_HIGH_SPEED  11'h001
`define SSR_SCALE_LOW_SPEED   11'h004

// last bit index of a character
`define SSR_LAST_BIT_8        4'h7
`define SSR_LAST_BIT_9        4'h8

`endif

// File: shared/ssr_pkg.sv
// Purpose: types shared by the synchronous serial receive port
// Assumes: ssr_defines.svh for all numeric constants
// Notes:   bus request and pin groups travel as packed structs
package ssr_pkg;

  // register bus request from software
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ssr_bus_req_type;

  // drive side of a two-way pin
  typedef struct packed {
    logic out;
    logic oe;
  } ssr_pin_drive_type;

  // master bit-clock phases
  typedef enum logic [1:0] {
    CK_IDLE,
    CK_HIGH,
    CK_LOW
  } ssr_ck_state_type;

endpackage
